// [hw/lpt_params.svh]
// Register offsets, field positions, reset values and counts for the LCD pixel clock and bias timing block.
// Assumes inclusion by bare name from the design modules and the testbench.
`ifndef LPT_PARAMS_SVH
`define LPT_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define LPT_OFF_CTRL 4'h0
`define LPT_OFF_TIMING 4'h4
`define LPT_OFF_STATUS 4'h8

// ----------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------
`define LPT_CTRL_ENABLE_BIT 0
`define LPT_CTRL_ACTIVE_BIT 1
`define LPT_TIMING_MASK 32'hff00_ffff

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define LPT_CTRL_RESET 2'h0
`define LPT_TIMING_RESET 32'h0000_0000
`define LPT_DIV_EXTRA 9'h002

`endif

// [hw/lpt_pkg.sv]
// Types shared by the LCD pixel clock and bias timing block.
// Assumes lpt_params.svh is on the include path.
package lpt_pkg;

    // ----------------------------------------------------------------
    // Register layouts
    // ----------------------------------------------------------------
    typedef struct packed {
        logic active;
        logic enable;
    } lpt_ctrl_s;

    typedef struct packed {
        logic [7:0] frame_start_wait;
        logic [7:0] reserved;
        logic [7:0] bias_toggle_period;
        logic [7:0] pixel_clock_divisor;
    } lpt_timing_s;

    // ----------------------------------------------------------------
    // Frame sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_DATA = 3'b100
    } lpt_state_e;

endpackage

// [hw/lpt_pix_div.sv]
// Pixel clock divider: half period of divisor plus two clock cycles.
// Assumes the divisor is non-zero and is steady while run is high.
`timescale 1ns/10ps
`include "lpt_params.svh"

module lpt_pix_div (
    input wire logic clk_i,            // System clock.
    input wire logic reset_n_i,        // Asynchronous reset, active low.
    input wire logic run_i,            // Divider runs while high.
    input wire logic [7:0] divisor_i,  // Pixel clock divisor.
    output logic pclk_o,               // Divided clock level.
    output logic rise_o                // Pulse in the first cycle of a high phase.
);

    logic [8:0] cnt;
    wire [8:0] last = {1'b0, divisor_i} + `LPT_DIV_EXTRA - 9'h001;  // see R4
    wire half_end = (cnt == last);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt <= 9'h000;
            pclk_o <= 1'b0;
            rise_o <= 1'b0;
        end else if (!run_i) begin
            cnt <= 9'h000;
            pclk_o <= 1'b0;
            rise_o <= 1'b0;
        end else begin
            cnt <= half_end ? 9'h000 : cnt + 9'h001;
            pclk_o <= half_end ? ~pclk_o : pclk_o;
            rise_o <= half_end & ~pclk_o;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_div_half_end: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R4
        run_i && half_end ##1 run_i |-> pclk_o != $past(pclk_o) && cnt == 9'h000)
        else $error("pixel clock did not toggle at end of half period");
    a_div_half_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R2
        run_i && !half_end |=> $stable(pclk_o))
        else $error("pixel clock toggled before divisor count elapsed");
    a_div_idle_low: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R15
        !run_i |=> !pclk_o && cnt == 9'h000 && !rise_o)
        else $error("divider not idle while stopped");

endmodule // lpt_pix_div

// [hw/lpt_timing.sv]
// LCD pixel clock, bias pin and beginning-of-frame wait timing with an Avalon-MM register slave.
// Assumes a single 100 MHz clock and software that only changes timing fields while disabled.
//
// Contract
// R1: Non-zero frame start wait inserts that value plus one line clocks before pixels.
// R2: An 8-bit pixel clock divisor field selects the pixel clock frequency.
// R3: Software writes divisor values 1 to 255 only; zero is illegal.
// R4: Pixel clock equals CPU clock over twice divisor plus two.
// R5: The 8-bit bias toggle period sets line clocks between bias pin toggles.
// R6: In passive mode, enabling loads the period into an 8-bit line-clock down counter.
// R7: At zero the counter stops, the bias pin inverts, the counter reloads and repeats.
// R8: Software writes the bias period as the wanted line count minus one.
// R9: Software should set the bias period to maximum for self-switching panels.
// R10: In active mode the bias period has no effect on the bias pin.
// R11: In active mode the bias pin is an output enable while pixels are driven.
// R12: In active mode the pixel clock toggles continuously.
// R13: Display type bit one selects active mode, zero selects passive mode.
// R14: Software disables the controller before changing timing fields.
// R15: While disabled, bias counter and divider stay idle with the bias pin low.
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
`include "lpt_params.svh"

module lpt_timing import lpt_pkg::*; #(
    parameter int LINE_PIXELS = 16,  // Pixel clocks per line.
    parameter int FRAME_LINES = 8    // Data lines per frame.
) (
    input wire logic clk_i,                // System clock, 100 MHz.
    input wire logic reset_n_i,            // Asynchronous reset, active low.
    input wire logic [3:0] avs_address_i,  // Byte address.
    input wire logic avs_read_i,           // Read request.
    input wire logic avs_write_i,          // Write request.
    input wire logic [31:0] avs_writedata_i,  // Write data.
    input wire logic [3:0] avs_byteenable_i,  // Write byte lanes.
    output logic [31:0] avs_readdata_o,    // Read data.
    output logic avs_waitrequest_o,        // Stall, active high.
    output logic pclk_o,                   // Pixel clock to the panel.
    output logic bias_o,                   // Bias pin or output enable.
    output logic pixel_valid_o,            // Pixels are being driven.
    output logic line_clk_o                // One-cycle pulse at each line end.
);

    localparam int PW = $clog2(LINE_PIXELS + 1);

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    lpt_ctrl_s ctrl;
    logic [31:0] timing_q;
    lpt_state_e state;
    logic [7:0] bcnt;
    logic [8:0] lcnt;

    wire bus_req = avs_read_i | avs_write_i;
    wire wr_take = avs_write_i & ~avs_waitrequest_o;
    wire sel_ctrl = (avs_address_i == `LPT_OFF_CTRL);
    wire sel_timing = (avs_address_i == `LPT_OFF_TIMING);
    wire sel_status = (avs_address_i == `LPT_OFF_STATUS);
    wire lpt_timing_s tf = lpt_timing_s'(timing_q & `LPT_TIMING_MASK);
    wire [31:0] status_word = {27'h0, state == ST_DATA, state == ST_WAIT, pixel_valid_o, bias_o, pclk_o};
    wire [31:0] rd_mux = sel_ctrl ? {30'h0, ctrl} :
                         sel_timing ? 32'(tf) :
                         sel_status ? status_word : 32'h0000_0000;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0000_0000;
        end else begin
            avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
            avs_readdata_o <= rd_mux;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl <= `LPT_CTRL_RESET;
        end else if (wr_take && sel_ctrl && avs_byteenable_i[0]) begin
            ctrl <= lpt_ctrl_s'(avs_writedata_i[1:0]);  // see R13
        end
    end

    // Each byte lane picks its own next value, so one register process owns the whole word.
    wire [31:0] next_timing;

    for (genvar b = 0; b < 4; b++) begin : g_tlane
        assign next_timing[8*b +: 8] = (wr_take && sel_timing && avs_byteenable_i[b]) ?
                                       avs_writedata_i[8*b +: 8] : timing_q[8*b +: 8];
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            timing_q <= `LPT_TIMING_RESET;
        end else begin
            timing_q <= next_timing;
        end
    end

    // ----------------------------------------------------------------
    // Pixel clock and line clock
    // ----------------------------------------------------------------
    logic div_pclk;
    logic pix_rise;
    logic [PW-1:0] pix_cnt;

    lpt_pix_div u_div (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .run_i(ctrl.enable),                   // see R15
        .divisor_i(tf.pixel_clock_divisor),    // see R2
        .pclk_o(div_pclk),
        .rise_o(pix_rise)
    );

    wire line_end = pix_rise && (pix_cnt == PW'(LINE_PIXELS - 1));

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pix_cnt <= '0;
        end else if (!ctrl.enable || line_end) begin
            pix_cnt <= '0;
        end else if (pix_rise) begin
            pix_cnt <= pix_cnt + PW'(1);
        end
    end

    // ----------------------------------------------------------------
    // Frame sequencer
    // ----------------------------------------------------------------
    lpt_state_e next_state;
    logic [8:0] next_lcnt;
    wire wait_on = (tf.frame_start_wait != 8'h00);
    wire lcnt_zero = (lcnt == 9'h000);

    always_comb begin
        next_state = state;
        next_lcnt = lcnt;
        unique case (state)
            ST_IDLE: begin
                if (wait_on) begin
                    next_state = ST_WAIT;
                    next_lcnt = {1'b0, tf.frame_start_wait};  // see R1
                end else begin
                    next_state = ST_DATA;
                    next_lcnt = 9'(FRAME_LINES - 1);
                end
            end
            ST_WAIT: begin
                if (line_end && lcnt_zero) begin
                    next_state = ST_DATA;
                    next_lcnt = 9'(FRAME_LINES - 1);
                end else if (line_end) begin
                    next_lcnt = lcnt - 9'h001;
                end
            end
            ST_DATA: begin
                if (line_end && lcnt_zero) begin
                    next_state = ST_IDLE;
                end else if (line_end) begin
                    next_lcnt = lcnt - 9'h001;
                end
            end
        endcase
        if (!ctrl.enable) begin
            next_state = ST_IDLE;
            next_lcnt = 9'h000;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= ST_IDLE;
            lcnt <= 9'h000;
        end else begin
            state <= next_state;
            lcnt <= next_lcnt;
        end
    end

    // ----------------------------------------------------------------
    // Bias counter and pin outputs
    // ----------------------------------------------------------------
    wire passive_run = ctrl.enable && !ctrl.active;
    wire bias_flip = passive_run && line_end && (bcnt == 8'h00);
    wire data_next = ctrl.enable && (next_state == ST_DATA);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bcnt <= 8'h00;
        end else if (!ctrl.enable || bias_flip) begin
            bcnt <= tf.bias_toggle_period;  // see R6
        end else if (passive_run && line_end) begin
            bcnt <= bcnt - 8'h01;  // see R5
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bias_o <= 1'b0;
            pixel_valid_o <= 1'b0;
            pclk_o <= 1'b0;
            line_clk_o <= 1'b0;
        end else begin
            bias_o <= !ctrl.enable ? 1'b0 : ctrl.active ? data_next : bias_o ^ bias_flip;  // see R7, R10, R11
            pixel_valid_o <= data_next;
            pclk_o <= div_pclk & (ctrl.active | data_next);  // see R12
            line_clk_o <= line_end;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    a_idle_pins_low: assert property (!ctrl.enable |=> !bias_o && !pclk_o && !pixel_valid_o) // see R15
        else $error("pins not idle while disabled");
    a_active_oe_match: assert property (ctrl.enable && ctrl.active |-> bias_o == pixel_valid_o) // see R11
        else $error("output enable does not follow pixel data");
    a_bias_toggle_reload: assert property (bias_flip |=> bias_o != $past(bias_o) && bcnt == $past(tf.bias_toggle_period)) // see R7
        else $error("bias pin did not toggle and reload at zero");
    a_bias_count_down: assert property (passive_run && line_end && bcnt != 8'h00 |=> bcnt == 8'($past(bcnt) - 8'h01)) // see R6
        else $error("bias counter did not decrement on line clock");
    a_bias_hold_between: assert property (passive_run && !bias_flip ##1 passive_run |-> $stable(bias_o)) // see R5
        else $error("bias pin moved between toggles");
    a_active_no_count: assert property (ctrl.enable && ctrl.active ##1 ctrl.enable |-> $stable(bcnt)) // see R10
        else $error("bias counter ran in active mode");
    a_wait_entry: assert property (state == ST_IDLE && ctrl.enable && wait_on |=> state == ST_WAIT && lcnt == {1'b0, $past(tf.frame_start_wait)}) // see R1
        else $error("frame start wait not loaded");
    a_wait_exit: assert property (state == ST_WAIT && ctrl.enable && !(line_end && lcnt_zero) |=> state != ST_DATA) // see R1
        else $error("pixels started before frame start wait ended");
    a_active_pclk_free: assert property (ctrl.enable && ctrl.active && pix_rise ##1 ctrl.enable |-> pclk_o) // see R12
        else $error("pixel clock gated in active mode");

    c_passive_toggle: cover property (bias_flip ##1 bias_o);
    c_wait_to_data: cover property (state == ST_WAIT ##[1:1000] state == ST_DATA);
    c_active_frame: cover property (ctrl.active && pixel_valid_o && bias_o);

endmodule // lpt_timing

// [tb/lpt_panel_model.sv]
// Panel-side monitor of the LCD pixel clock and bias pins.
// Assumes the pins are sampled on the system clock; the panel drives nothing back.
`timescale 1ns/10ps

module lpt_panel_model (
    input wire logic clk_i,       // System clock.
    input wire logic pclk_i,      // Pixel clock pin.
    input wire logic bias_i,      // Bias or output enable pin.
    input wire logic line_clk_i,  // Line end pulse.
    output int hi_len = 0,        // Cycles of the last high pixel clock phase.
    output int bias_lines = 0,    // Line clocks in the last bias interval.
    output int bias_flips = 0     // Bias pin transitions seen.
);
    logic last_pclk = 1'b0;
    logic last_bias = 1'b0;
    int run = 0;
    int lines = 0;

    // A line end that lands with the bias flip closes the interval it ends.
    always @(posedge clk_i) begin
        last_pclk <= pclk_i;
        last_bias <= bias_i;
        run <= (pclk_i == last_pclk) ? run + 1 : 1;
        if (last_pclk && !pclk_i) hi_len <= run;
        lines <= (bias_i != last_bias) ? 0 : lines + int'(line_clk_i);
        if (bias_i != last_bias) begin
            bias_lines <= lines + int'(line_clk_i);
            bias_flips <= bias_flips + 1;
        end
    end
endmodule // lpt_panel_model

// [tb/tb_lpt_timing.sv]
// Self-checking bench for the LCD pixel clock and bias timing block.
// Assumes the panel monitor model and a 100 MHz clock; registers are reached over Avalon-MM.
`timescale 1ns/10ps
`include "lpt_params.svh"

module tb_lpt_timing import lpt_pkg::*;;
    localparam int LP = 4;
    logic clk_i = 1'b0, reset_n_i = 1'b0, rd = 1'b0, wr = 1'b0, wait_o, pclk_o, bias_o, pv_o, lclk_o;
    logic [3:0] adr = 4'h0, be = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, rv, v;
    int n_fail = 0, n_tests = 0, hi_len, bias_lines, bias_flips, c, c0, tg, k, nl;
    logic [7:0] d, p, w, lastp;

    lpt_timing #(.LINE_PIXELS(LP), .FRAME_LINES(2)) lpt_timing_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o), .pclk_o(pclk_o),
        .bias_o(bias_o), .pixel_valid_o(pv_o), .line_clk_o(lclk_o));
    lpt_panel_model lpt_panel_model_i (.clk_i(clk_i), .pclk_i(pclk_o), .bias_i(bias_o), .line_clk_i(lclk_o),
        .hi_len(hi_len), .bias_lines(bias_lines), .bias_flips(bias_flips));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // One Avalon-MM access; read data lands in rv.
    task automatic bus(input logic w_en, input logic [3:0] a, input logic [31:0] dat);
        int i;
        @(posedge clk_i);
        adr <= a; wr <= w_en; rd <= !w_en; wdat <= dat; be <= 4'hf;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_i);
            if (wait_o === 1'b0) break;
        end
        if (i == 50) begin n_fail++; give_verdict; end
        rv = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    // Fields change only while disabled, and the divisor is never zero.
    task automatic go(input logic act, input logic [7:0] dv, input logic [7:0] pr, input logic [7:0] fw);
        lpt_timing_s t;
        t = '{fw, 8'h00, pr, dv};
        bus(1'b1, `LPT_OFF_CTRL, 32'h0);
        bus(1'b1, `LPT_OFF_TIMING, t);
        bus(1'b1, `LPT_OFF_CTRL, {30'h0, act, 1'b1});
    endtask

    // Counts cycles, and line clock pulses seen, until pixels start or the bias flip count is reached.
    task automatic wait_cnt(input int target, output int n, output int lines);
        lines = 0;
        for (n = 0; n < 20000; n++) begin
            lines += int'(lclk_o === 1'b1);
            if (target < 0 ? pv_o === 1'b1 : bias_flips >= target) break;
            @(posedge clk_i);
        end
        if (n == 20000) begin n_fail++; give_verdict; end
    endtask

    initial begin
        v = $urandom(87);
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        bus(1'b0, `LPT_OFF_CTRL, 32'h0); chk(rv, 32'h0);
        bus(1'b0, `LPT_OFF_TIMING, 32'h0); chk(rv, `LPT_TIMING_RESET);
        bus(1'b0, `LPT_OFF_STATUS, 32'h0); chk(rv, 32'h0);
        bus(1'b1, 4'hc, 32'hffff_ffff);
        bus(1'b0, 4'hc, 32'h0); chk(rv, 32'h0);
        bus(1'b1, `LPT_OFF_CTRL, 32'hffff_fffe);
        bus(1'b0, `LPT_OFF_CTRL, 32'h0); chk(rv, 32'h2);
        for (k = 0; k < 5; k++) begin
            v = (k == 0) ? 32'hffff_ffff : $urandom;
            if (v[7:0] == 8'h00) v[7:0] = 8'h01;
            bus(1'b1, `LPT_OFF_TIMING, v);
            bus(1'b0, `LPT_OFF_TIMING, 32'h0); chk(rv, v & `LPT_TIMING_MASK);
        end
        $display("Test registers done");
        for (k = 0; k < 3; k++) begin
            d = (k == 0) ? 8'h01 : 8'h01 + 8'($urandom % 4);
            p = (k == 0) ? 8'h00 : 8'($urandom % 3);
            go(1'b0, d, p, 8'h00);
            wait_cnt(bias_flips + 3, c, nl);
            chk(hi_len, 32'(d) + 32'h2);
            chk(bias_lines, 32'(p) + 32'h1);
        end
        $display("Test passive timing done");
        d = 8'h01 + 8'($urandom % 3);
        go(1'b1, d, 8'hff, 8'h01);
        tg = 0;
        lastp = 8'(pclk_o);
        for (k = 0; k < 800; k++) begin
            @(posedge clk_i);
            if (bias_o !== pv_o) chk({31'h0, bias_o}, {31'h0, pv_o});
            if (pv_o === 1'b0 && pclk_o !== lastp[0]) tg++;
            lastp = 8'(pclk_o);
        end
        chk(32'(tg > 0), 32'h1);
        chk(hi_len, 32'(d) + 32'h2);
        $display("Test active mode done");
        for (k = 0; k < 4; k++) begin
            w = (k == 0) ? 8'h00 : (k == 1) ? 8'h01 : (k == 2) ? 8'hff : 8'h02 + 8'($urandom % 250);
            go(1'b1, 8'h01, 8'h00, w);
            wait_cnt(-1, c, nl);
            chk(nl, (w == 8'h00) ? 32'h0 : 32'(w) + 32'h1);
            // A line clock closes at the last pixel clock rise of a line, half a period before its end.
            if (k == 0) c0 = c;
            else chk(c - c0, (32'(w) + 32'h1) * LP * 2 * 3 - 3);
        end
        $display("Test frame start wait done");
        bus(1'b1, `LPT_OFF_CTRL, 32'h0);
        repeat (10) @(posedge clk_i);
        for (k = 0; k < 30; k++) begin
            @(posedge clk_i);
            chk({29'h0, pclk_o, bias_o, pv_o}, 32'h0);
        end
        $display("Test disable done");
        give_verdict;
    end
endmodule // tb_lpt_timing
